// ### pcrc_pkg.sv
// Purpose: Shared constants and types for the programmable CRC generator.
// Assumes: AHB-Lite register slave, 32-bit data, one word per register.
// Notes: Offsets are byte addresses inside the block.
package pcrc_pkg;
   // Register byte offsets
   localparam logic [7:0] PCRC_OFS_CONTROL = 8'h00;
   localparam logic [7:0] PCRC_OFS_POLY = 8'h04;
   localparam logic [7:0] PCRC_OFS_DATA = 8'h08;
   localparam logic [7:0] PCRC_OFS_POWER = 8'h0C;
   // Control register field positions
   localparam int PCRC_POS_LEN = 0;
   localparam int PCRC_POS_GO = 4;
   localparam int PCRC_POS_EMPTY = 6;
   localparam int PCRC_POS_FULL = 7;
   localparam int PCRC_POS_COUNT = 8;
   localparam int PCRC_POS_SIDL = 13;
   // Power register field positions
   localparam int PCRC_POS_SLEEP = 0;
   localparam int PCRC_POS_IDLE = 1;
   // Depth thresholds
   localparam logic [3:0] PCRC_LEN_WIDE = 4'h7;
   localparam logic [4:0] PCRC_DEPTH_WIDE = 5'h08;
   localparam logic [4:0] PCRC_DEPTH_NARROW = 5'h10;
   // Reset values
   localparam logic [14:0] PCRC_RST_TERMS = 15'h0000;
   localparam logic [3:0] PCRC_RST_LEN = 4'h0;
   localparam logic [15:0] PCRC_RST_REM = 16'h0000;
   // Shifter states
   typedef enum logic [1:0] {
      PCRC_SH_IDLE = 2'b01,
      PCRC_SH_BUSY = 2'b10
   } pcrc_shift_type;
endpackage : pcrc_pkg

// ### pcrc_fifo.sv
// Purpose: Word store for queued CRC input words.
// Assumes: Caller keeps count and decides wrap on overfill.
// Notes: Flip-flop storage addressed by index; pointers wrap at depth_now.
`timescale 1ns/1ps
module pcrc_fifo
   import pcrc_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   input wire logic [4:0] depth_now,
   // Head word
   output logic [WIDTH-1:0] head_data
);
   logic [WIDTH-1:0] mem [DEPTH];  // Word storage
   logic [4:0] wr_ptr;  // Next slot written
   logic [4:0] rd_ptr;  // Slot at head

   // Storage writes, no reset needed for data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[3:0]] <= push_data;
      end
   end

   // Pointers wrap at the live depth, which halves for long polynomials
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
      end else if (flush) begin
         // Overfill restart: the stored words are abandoned
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr + 5'h01 >= depth_now) ? 5'h00 : wr_ptr + 5'h01;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr + 5'h01 >= depth_now) ? 5'h00 : rd_ptr + 5'h01;
         end
      end
   end

   assign head_data = mem[rd_ptr[3:0]];
endmodule : pcrc_fifo

// ### pcrc_lfsr.sv
// Purpose: One-bit-per-clock CRC feedback register with programmable taps.
// Assumes: Length field holds polynomial length minus one.
// Notes: Top term is implied at the selected length, x^0 always applied.
`timescale 1ns/1ps
module pcrc_lfsr
   import pcrc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic [14:0] terms,
   input wire logic [3:0] len_m1,
   // Bit stream
   input wire logic step,
   input wire logic data_bit,
   // Remainder
   output logic [15:0] remainder
);
   logic fb;  // Feedback bit from the top stage
   logic [15:0] taps;  // x^0 plus enabled inner terms
   logic [15:0] next_rem;

   // Feedback and shift, masked to the live length
   always_comb begin
      fb = remainder[len_m1] ^ data_bit;
      taps = {terms, 1'b1};
      next_rem = {remainder[14:0], 1'b0} ^ (fb ? taps : 16'h0000);
      for (int i = 0; i < 16; i++) begin
         if (i > int'(len_m1)) begin
            next_rem[i] = 1'b0;
         end
      end
   end

   // Remainder register, advances only when a bit is fed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remainder <= PCRC_RST_REM;
      end else if (step) begin
         remainder <= next_rem;
      end
   end
endmodule : pcrc_lfsr

// ### pcrc_top.sv
// Purpose: Programmable CRC generator with AHB-Lite register slave.
// Assumes: Single transfers of word, halfword or byte size; sleep and idle come as inputs.
// Notes: Interrupt line is a one-cycle pulse on count going 1 to 0.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pcrc_top
   import pcrc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Power state
   input wire logic sleep_req,
   input wire logic idle_req,
   // Event
   output logic crc_irq
);
   // Software-visible state
   logic [14:0] poly_term_reg;  // Inner term enables
   logic [3:0] poly_length_m1;  // Length minus one
   logic shifter_go;  // Start request
   logic stop_in_idle;  // Freeze in idle
   logic [4:0] valid_word_count;  // Queued words
   logic fifo_full_flag;  // Count at live depth
   logic fifo_empty_flag;  // Count at zero
   // Bus data phase capture
   // The address phase is registered so the write data, which only
   // arrives one cycle later, can be matched to its target register.
   logic dp_write;  // Data phase of an accepted write
   logic dp_read;  // Data phase of a read
   logic [7:0] dp_addr;  // Target offset of the data phase
   // Shifter
   pcrc_shift_type shift_state;
   logic [3:0] bit_idx;  // Bit of head word being fed
   logic frozen;  // Sleep or stopped idle
   logic step;
   logic word_done;
   logic data_push;
   logic overfill;
   logic [4:0] depth_now;
   logic [15:0] head_word;
   logic [15:0] remainder;
   logic [4:0] next_count;
   // The remainder is never cleared by go; only reset restarts it, so a
   // long message may be fed in several bursts of queued words.

   // Live depth follows the length field
   // Storage always holds 16 words; for long polynomials only half of it
   // is used, so the pointers must wrap at the live depth, not at 16.
   // Changing the length with words queued leaves the queue undefined.
   assign depth_now = (poly_length_m1 > PCRC_LEN_WIDE) ?
                      PCRC_DEPTH_WIDE : PCRC_DEPTH_NARROW;
   // Clocks are gone in sleep, or in idle with stop bit set
   assign frozen = sleep_req | (idle_req & stop_in_idle);
   // One bit per clock while busy and not frozen
   assign step = (shift_state == PCRC_SH_BUSY) && !frozen;
   // Word ends when its last bit, bit zero, leaves
   assign word_done = step && (bit_idx == 4'h0);
   // The data write lands on any accepted write to the data offset outside a freeze;
   // no byte lanes are decoded from hsize, so halfword writes also count
   assign data_push = dp_write && (dp_addr == PCRC_OFS_DATA) && !frozen;
   assign overfill = data_push && fifo_full_flag;

   // AHB address phase capture; zero-wait slave always ready
   // Byte-sized writes are dropped here when the word is wider than a
   // byte, so a partial word can never be queued as if it were whole.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready) begin
         dp_write <= hsel && htrans[1] && hwrite && (hsize != 3'h0 ||
                     poly_length_m1 < 4'h8);
         dp_read <= hsel && htrans[1] && !hwrite;
         dp_addr <= haddr;
      end
   end

   // Response is always OKAY with no wait states
   // Kept as flops so every top-level output starts at a register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data registered from the address phase for a flop-driven output
   // Status is sampled at the address phase edge; a data write in the
   // cycle just before is not yet visible, hence the one-cycle spacing
   // that software keeps between a data write and a count read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr)
            PCRC_OFS_CONTROL: begin
               hrdata <= 32'h0000_0000;
               hrdata[PCRC_POS_LEN +: 4] <= poly_length_m1;
               hrdata[PCRC_POS_GO] <= shifter_go;
               hrdata[PCRC_POS_EMPTY] <= fifo_empty_flag;
               hrdata[PCRC_POS_FULL] <= fifo_full_flag;
               hrdata[PCRC_POS_COUNT +: 5] <= valid_word_count;
               hrdata[PCRC_POS_SIDL] <= stop_in_idle;
            end
            PCRC_OFS_POLY: begin
               hrdata <= {16'h0000, poly_term_reg, 1'b0};
            end
            PCRC_OFS_DATA: begin
               hrdata <= {16'h0000, remainder};
            end
            PCRC_OFS_POWER: begin
               hrdata <= {30'h0000_0000, idle_req, sleep_req};
            end
            default: begin
               hrdata <= 32'h0000_0000;  // Unmapped reads as zero
            end
         endcase
      end
   end

   // Configuration registers written in the data phase
   // Writes during a freeze are dropped: with its clock stopped the block
   // would not see them either, and dropping keeps the state consistent.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         poly_term_reg <= PCRC_RST_TERMS;
         poly_length_m1 <= PCRC_RST_LEN;
         shifter_go <= 1'b0;
         stop_in_idle <= 1'b0;
      end else if (dp_write && !frozen) begin
         case (dp_addr)
            PCRC_OFS_CONTROL: begin
               poly_length_m1 <= hwdata[PCRC_POS_LEN +: 4];
               shifter_go <= hwdata[PCRC_POS_GO];
               stop_in_idle <= hwdata[PCRC_POS_SIDL];
            end
            PCRC_OFS_POLY: begin
               poly_term_reg <= hwdata[15:1];
            end
            default: begin
               poly_term_reg <= poly_term_reg;
            end
         endcase
      end
   end

   // Shifter: start needs go and words; stop only once FIFO is empty
   // The bit index counts down from the top bit of the word, so the
   // most significant bit enters the engine first and bit zero last.
   // Finishing a word stays in the busy state when more words are queued,
   // which keeps the cost at exactly one clock per bit.
   // A freeze holds both state and index where they stand.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_state <= PCRC_SH_IDLE;
         bit_idx <= 4'h0;
      end else if (!frozen) begin
         case (shift_state)
            PCRC_SH_IDLE: begin
               if (shifter_go && valid_word_count != 5'h00) begin
                  shift_state <= PCRC_SH_BUSY;
                  bit_idx <= poly_length_m1;
               end
            end
            PCRC_SH_BUSY: begin
               if (overfill) begin
                  shift_state <= PCRC_SH_IDLE;  // Queue abandoned
               end else if (word_done) begin
                  // Go cleared keeps draining until count hits zero
                  if (next_count == 5'h00) begin
                     shift_state <= PCRC_SH_IDLE;
                  end
                  bit_idx <= poly_length_m1;
               end else begin
                  bit_idx <= bit_idx - 4'h1;
               end
            end
            default: begin
               shift_state <= PCRC_SH_IDLE;
            end
         endcase
      end
   end

   // Count: push adds, finished word subtracts, overfill wraps to zero
   // A push and a finished word in one cycle cancel out, so the count
   // never glitches through a false zero while the queue is busy.
   always_comb begin
      next_count = valid_word_count;
      if (overfill) begin
         next_count = 5'h00;
      end else begin
         if (data_push) begin
            next_count = next_count + 5'h01;
         end
         if (word_done) begin
            next_count = next_count - 5'h01;
         end
      end
   end

   // Count and flags; a freeze holds them as they stand
   // Flags come from the next count so they never lag the count that
   // software reads back alongside them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_word_count <= 5'h00;
         fifo_full_flag <= 1'b0;
         fifo_empty_flag <= 1'b1;
      end else begin
         valid_word_count <= next_count;
         fifo_full_flag <= (next_count == depth_now);
         fifo_empty_flag <= (next_count == 5'h00);
      end
   end

   // Event pulse on 1 to 0; overfill wrap is not a drain, so no event.
   // Not gated by the freeze, so a pending event still goes out.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_irq <= 1'b0;
      end else begin
         crc_irq <= (valid_word_count == 5'h01) && (next_count == 5'h00) &&
                    !overfill;
      end
   end

   // Input word store
   // The overfill write itself is discarded along with the queue.
   pcrc_fifo #(
      .WIDTH(16),
      .DEPTH(16)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(overfill),
      .push(data_push && !overfill),
      .push_data(hwdata[15:0]),
      .pop(word_done && !overfill),
      .depth_now(depth_now),
      .head_data(head_word)
   );

   // Feedback engine fed MSB first from the head word
   // The engine only advances on a step, so idle and frozen cycles
   // leave the remainder untouched for software to read.
   pcrc_lfsr u_lfsr (
      .clk(clk),
      .rst_n(rst_n),
      .terms(poly_term_reg),
      .len_m1(poly_length_m1),
      .step(step),
      .data_bit(head_word[bit_idx]),
      .remainder(remainder)
   );
endmodule : pcrc_top

// ### pcrc_monitor.sv
// Purpose: Port-level checks for the programmable CRC generator.
// Assumes: Zero-wait slave; read data stands in the data phase.
// Notes: Flag checks run on every control read the bench makes.
`timescale 1ns/1ps
module pcrc_monitor
   import pcrc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus side
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Power and event
   input wire logic sleep_req,
   input wire logic crc_irq
);
   logic rd_ctl; // Data phase of a control read
   logic rd_poly; // Data phase of a term read
   logic [4:0] depth; // Depth implied by the length field read back
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Track read data phases so read fields are checked against each other
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ctl <= 1'b0;
         rd_poly <= 1'b0;
      end else begin
         rd_ctl <= hsel && htrans[1] && hready && !hwrite
            && haddr == PCRC_OFS_CONTROL;
         rd_poly <= hsel && htrans[1] && hready && !hwrite
            && haddr == PCRC_OFS_POLY;
      end
   end
   assign depth = (hrdata[3:0] > PCRC_LEN_WIDE) ? PCRC_DEPTH_WIDE
      : PCRC_DEPTH_NARROW;
   a_empty_flag: assert property (rd_ctl |->
      hrdata[6] == (hrdata[12:8] == 5'h00)) else $error("empty flag wrong");
   a_full_flag: assert property (rd_ctl |->
      hrdata[7] == (hrdata[12:8] == depth)) else $error("full flag wrong");
   a_count_bound: assert property (rd_ctl |->
      hrdata[12:8] <= depth) else $error("count above depth");
   a_poly_bit0: assert property (rd_poly |-> !hrdata[0])
      else $error("term bit zero reads set");
   a_irq_pulse: assert property (crc_irq |=> !crc_irq)
      else $error("event longer than one cycle");
   a_sleep_quiet: assert property (sleep_req [*3] |-> !crc_irq)
      else $error("event while frozen");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   a_reset_quiet: assert property ($rose(rst_n) |->
      !crc_irq && hrdata == 32'h0000_0000) else $error("reset state wrong");
endmodule : pcrc_monitor

bind pcrc_top pcrc_monitor i_pcrc_monitor (.clk(clk), .rst_n(rst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .sleep_req(sleep_req), .crc_irq(crc_irq));

// ### pcrc_tb.sv
// Purpose: Self-checking bench for the programmable CRC generator.
// Assumes: Single AHB-Lite transfers of word or byte size, one request at a time.
// Notes: The remainder model restarts at each reset of the block.
`timescale 1ns/1ps
module testbench;
   import pcrc_pkg::*;
   logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic sleep_req, idle_req, crc_irq;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, q;
   logic [15:0] exp_rem, poly; // Model remainder and taps with x^0
   int len, miscompares, cmp_count, irq_n;
   assign hready = hreadyout; // Single slave drives bus ready
   pcrc_top i_pcrc_top (.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
      .idle_req(idle_req), .crc_irq(crc_irq));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Count one-cycle event pulses
   always @(posedge clk) if (crc_irq === 1'b1) irq_n++;
   // Bit-serial model, MSB first, feedback is top bit xor data bit
   function automatic logic [15:0] crc_f(input logic [15:0] r,
      input logic [15:0] w);
      logic fb;
      for (int i = len; i >= 0; i--) begin
         fb = r[len] ^ w[i];
         r = r << 1;
         if (fb) r = r ^ poly;
      end
      return r & ((17'h1 << (len + 1)) - 17'h1);
   endfunction : crc_f
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // One transfer: address phase, then data phase, each held until ready
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [2:0] sz);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      q = hrdata;
      if (n >= 50) begin
         miscompares++;
         summarize();
      end
   endtask : bus
   task automatic push(input logic [15:0] w, input logic [2:0] sz);
      bus(1'b1, PCRC_OFS_DATA, {16'h0000, w}, sz);
      exp_rem = crc_f(exp_rem, w);
   endtask : push
   // Poll until the queue reports empty, bounded
   task automatic wait_empty;
      int n;
      n = 0;
      do begin
         bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
         n++;
      end while (q[PCRC_POS_EMPTY] !== 1'b1 && n < 100);
      if (n >= 100) begin
         miscompares++;
         summarize();
      end
   endtask : wait_empty
   task automatic do_reset(input logic [15:0] p, input int l);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      exp_rem = 16'h0000;
      irq_n = 0;
      poly = p;
      len = l;
      bus(1'b1, PCRC_OFS_POLY, {16'h0000, p}, 3'h2);
      bus(1'b1, PCRC_OFS_CONTROL, l, 3'h2);
   endtask : do_reset
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, sleep_req, idle_req} = '0;
      hsize = 3'h2;
      rst_n = 1'b0;
      // Reset state, before any setup write
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q, 32'h0000_0040);
      bus(1'b0, PCRC_OFS_POLY, 32'h0, 3'h2);
      chk(q, 32'h0000_0000);
      $display("test reset done");
      // Sixteen-bit setup, three queued words, then shift
      do_reset(16'h1021, 15);
      bus(1'b0, PCRC_OFS_POLY, 32'h0, 3'h2);
      chk(q, 32'h0000_1020);
      for (int i = 0; i < 3; i++) push(16'hA5C3 + 16'h1357 * i, 3'h2);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q[12:8], 5'h03);
      bus(1'b1, PCRC_OFS_CONTROL, 32'h1F, 3'h2);
      repeat (40) @(posedge clk);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q[12:8], 5'h01);
      wait_empty();
      chk(irq_n, 1);
      bus(1'b0, PCRC_OFS_DATA, 32'h0, 3'h2);
      chk(q, exp_rem);
      $display("test ccitt done");
      // Byte words: deep queue, fill to full, then overfill
      do_reset(16'h0007, 7);
      for (int i = 0; i < 16; i++) push(i, 3'h0);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q[12:6], {5'h10, 2'b10});
      push(16'h00FF, 3'h0);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk({q[12:6], irq_n[0]}, {5'h00, 2'b01, 1'b0});
      $display("test overfill done");
      // Nine-bit words: shallow queue, byte write, early go clear
      do_reset(16'h0133, 8);
      bus(1'b1, PCRC_OFS_DATA, 32'h0000_00AA, 3'h0);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q[12:8], 5'h00);
      for (int i = 0; i < 8; i++) push(16'h0155 + 16'h0021 * i, 3'h2);
      bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
      chk(q[12:6], {5'h08, 2'b10});
      bus(1'b1, PCRC_OFS_CONTROL, 32'h18, 3'h2);
      bus(1'b1, PCRC_OFS_CONTROL, 32'h08, 3'h2);
      wait_empty();
      bus(1'b0, PCRC_OFS_DATA, 32'h0, 3'h2);
      chk({irq_n[1:0], q}, {2'b01, 16'h0000, exp_rem});
      $display("test nine-bit done");
      // Sleep, idle with stop bit, idle with stop bit cleared
      for (int m = 0; m < 3; m++) begin
         do_reset(16'h1021, 15);
         bus(1'b1, PCRC_OFS_CONTROL, {m == 1, 13'h000F}, 3'h2);
         push(16'h1234, 3'h2);
         push(16'hFEDC, 3'h2);
         bus(1'b1, PCRC_OFS_CONTROL, {m == 1, 13'h001F}, 3'h2);
         if (m == 0) sleep_req <= 1'b1;
         else idle_req <= 1'b1;
         repeat (60) @(posedge clk);
         bus(1'b0, PCRC_OFS_CONTROL, 32'h0, 3'h2);
         chk(q[12:8], (m == 2) ? 5'h00 : 5'h02);
         sleep_req <= 1'b0;
         idle_req <= 1'b0;
         wait_empty();
         bus(1'b0, PCRC_OFS_DATA, 32'h0, 3'h2);
         chk({irq_n[1:0], q}, {2'b01, 16'h0000, exp_rem});
      end
      $display("test power done");
      summarize();
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule : testbench
